// ### dv/kbd_dispatch_checker.sv
`timescale 1ns/10ps
`include "kbd_dispatch_regs.vh"
module kbd_dispatch_checker (
  input wire       SYS_CLK,
  input wire       RESET_N,
  input wire       KEY_READY,
  input wire [5:0] CONTACT_OUT,
  input wire [5:0] CONTACT_OE,
  input wire       ACT_VALID,
  input wire [3:0] ACT_TYPE,
  input wire       ACT_STORE,
  input wire       ACT_OPEN_UI,
  input wire [1:0] TOGGLE_STATE,
  input wire       JUMP_VALID,
  input wire [6:0] JUMP_NUM,
  input wire       EDIT_DONE
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  a_idle_pin_high: assert property ((~CONTACT_OE & ~CONTACT_OUT) == 6'h00)
    else $error("Pin not configured as output is driven low");
  a_act_single: assert property (ACT_VALID |=> !ACT_VALID)
    else $error("Action pulse longer than one cycle");
  a_jump_single: assert property (JUMP_VALID |=> !JUMP_VALID)
    else $error("Jump pulse longer than one cycle");
  a_jump_range: assert property (JUMP_VALID |->
    JUMP_NUM >= 7'h01 && JUMP_NUM <= 7'h63)
    else $error("Jump number outside 1 to 99");
  a_store_on_set: assert property (ACT_VALID &&
    (ACT_TYPE == `ACT_CYCLE || ACT_TYPE == `ACT_SET) |-> ACT_STORE)
    else $error("Cycle or set action without store");
  a_jam_no_screen: assert property (ACT_VALID &&
    ACT_TYPE == `ACT_JAM |-> !ACT_OPEN_UI)
    else $error("Jam action opened a screen");
  a_scan_bounded: assert property ($fell(KEY_READY) |-> ##[1:60] KEY_READY)
    else $error("Table scan did not finish");
  a_toggle_cause: assert property ($changed(TOGGLE_STATE) |->
    $onehot(TOGGLE_STATE ^ $past(TOGGLE_STATE)) && ACT_TYPE == `ACT_TOGGLE)
    else $error("Toggle state changed without a single toggle");
  a_edit_single: assert property (EDIT_DONE |=> !EDIT_DONE)
    else $error("Commit pulse longer than one cycle");
endmodule // kbd_dispatch_checker

bind keyboard_shortcut_dispatcher kbd_dispatch_checker u_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .KEY_READY(KEY_READY),
  .CONTACT_OUT(CONTACT_OUT), .CONTACT_OE(CONTACT_OE),
  .ACT_VALID(ACT_VALID), .ACT_TYPE(ACT_TYPE), .ACT_STORE(ACT_STORE),
  .ACT_OPEN_UI(ACT_OPEN_UI), .TOGGLE_STATE(TOGGLE_STATE),
  .JUMP_VALID(JUMP_VALID), .JUMP_NUM(JUMP_NUM), .EDIT_DONE(EDIT_DONE));

// ### dv/kbd_far_side.sv
`timescale 1ns/10ps
module kbd_far_side (
  input  wire       clk,
  input  wire       key_ready,
  input  wire [5:0] pin_drive,
  input  wire [5:0] pin_oe,
  output reg        key_valid,
  output reg  [7:0] key_code,
  output reg  [2:0] key_mod,
  output wire [5:0] pin_level
);
  reg [5:0] closed;

  // Pull-up keeps open pins high; a closed switch grounds the wire
  assign pin_level = ~closed & (~pin_oe | pin_drive);

  initial begin
    key_valid = 1'b0;
    key_code = 8'h00;
    key_mod = 3'h0;
    closed = 6'h00;
  end

  task press(input [7:0] c, input [2:0] m);
    begin
      key_valid <= 1'b1;
      key_code <= c;
      key_mod <= m;
      @(posedge clk);
      while (!key_ready) @(posedge clk);
      key_valid <= 1'b0;
      // Released lines must not look like the last key
      key_code <= ~c;
      key_mod <= ~m;
    end
  endtask
endmodule // kbd_far_side

// ### dv/test_keyboard_shortcut_dispatcher.sv
`timescale 1ns/10ps
`include "kbd_dispatch_regs.vh"
module test_keyboard_shortcut_dispatcher;
  reg         sys_clk = 1'b0;
  reg         reset_n = 1'b0;
  reg  [11:0] awaddr = 12'h000, araddr = 12'h000;
  reg  [31:0] wdata = 32'h0;
  reg         awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg         arvalid = 1'b0, rready = 1'b0;
  reg  [2:0]  ts = 3'h0;
  wire        awready, wready, bvalid, arready, rvalid;
  wire [1:0]  bresp, rresp, tog;
  wire [31:0] rdata;
  wire        key_valid, key_ready, act_valid, act_store, act_open;
  wire [7:0]  key_code, act_target, act_value;
  wire [2:0]  key_mod;
  wire [5:0]  c_in, c_out, c_oe;
  wire [3:0]  act_type;
  wire [6:0]  jump_num;
  wire        jump_valid, edit_done;
  int         failures = 0, n_checks = 0, n_act = 0, n_jump = 0;
  int         n_done = 0, n0;
  reg  [11:0] l_act;
  reg  [6:0]  l_jump;

  always #12.5 sys_clk = ~sys_clk;

  keyboard_shortcut_dispatcher #(.DB_CYCLES(8)) DUT (
    .SYS_CLK(sys_clk), .RESET_N(reset_n),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
    .S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hf),
    .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
    .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
    .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
    .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .KEY_VALID(key_valid), .KEY_CODE(key_code), .KEY_MOD(key_mod),
    .KEY_READY(key_ready), .CONTACT_IN(c_in), .CONTACT_OUT(c_out),
    .CONTACT_OE(c_oe), .TRANSPORT_STATE(ts), .ACT_VALID(act_valid),
    .ACT_TYPE(act_type), .ACT_TARGET(act_target), .ACT_VALUE(act_value),
    .ACT_STORE(act_store), .ACT_OPEN_UI(act_open), .TOGGLE_STATE(tog),
    .JUMP_VALID(jump_valid), .JUMP_NUM(jump_num), .EDIT_DONE(edit_done));

  kbd_far_side kp (
    .clk(sys_clk), .key_ready(key_ready), .pin_drive(c_out),
    .pin_oe(c_oe), .key_valid(key_valid), .key_code(key_code),
    .key_mod(key_mod), .pin_level(c_in));

  always @(posedge sys_clk) begin
    if (act_valid) begin
      n_act <= n_act + 1;
      l_act <= {act_type, act_target};
    end
    if (jump_valid) begin
      n_jump <= n_jump + 1;
      l_jump <= jump_num;
    end
    if (edit_done) n_done <= n_done + 1;
  end

  task conclude;
    begin
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask

  task chk(input [31:0] g, input [31:0] e);
    begin
      n_checks++;
      if (g !== e) begin
        failures++;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task idle(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  task wr(input [11:0] a, input [31:0] d);
    begin
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge sys_clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      chk(bresp, 2'b00);
    end
  endtask

  task rd(input [11:0] a, input [31:0] e, input [1:0] er);
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge sys_clk);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      chk(rdata, e);
      chk(rresp, er);
    end
  endtask

  // Counts settle one edge late, so every wait ends with spare edges
  task key(input [7:0] c, input [2:0] m);
    begin
      kp.press(c, m);
      idle(2);
      while (!key_ready) @(posedge sys_clk);
      idle(3);
    end
  endtask

  task outcome(input int d, input [11:0] e);
    begin
      chk(n_act - n0, d);
      if (d != 0) chk(l_act, e);
    end
  endtask

  task hit(input [7:0] c, input [2:0] m, input int d, input [11:0] e);
    begin
      n0 = n_act;
      key(c, m);
      outcome(d, e);
    end
  endtask

  task pin(input int p, input int hold, input int d, input [11:0] e);
    begin
      n0 = n_act;
      kp.closed[p-1] <= 1'b1;
      idle(hold);
      kp.closed[p-1] <= 1'b0;
      idle(80);
      outcome(d, e);
    end
  endtask

  function [31:0] be(input [3:0] a, input [2:0] m, input [7:0] k,
                     input [7:0] t, input [7:0] v);
    be = {1'b1, a, m, k, t, v};
  endfunction

  initial begin
    idle(4);
    reset_n <= 1'b1;
    idle(1);
    rd(`A_CTRL, 32'h0, 2'b00);
    rd(`A_OUTSET, 32'h0, 2'b00);
    rd(12'h040, 32'h0, 2'b10);
    chk({c_oe, c_out}, 12'h03f);
    wr(`A_BIND0, be(`ACT_CYCLE, `M_SHIFT, `K_F1, 8'h12, 8'h00));
    wr(12'h104, be(`ACT_SET, `M_SHIFT, `K_F1, 8'h34, 8'h56));
    wr(12'h108, be(`ACT_JAM, `M_CTRL, `K_LA, 8'h07, 8'h00));
    wr(12'h10c, be(`ACT_SET, `M_NONE, 8'h42, 8'h09, 8'h01));
    wr(12'h110, be(`ACT_MOMENT, `M_NONE, 8'h92, 8'h05, 8'h00));
    wr(12'h114, be(`ACT_TOGGLE, `M_NONE, 8'hf3, 8'h00, 8'h00));
    wr(12'h118, be(`ACT_MOMENT, `M_NONE, `K_C1, 8'h05, 8'h00));
    wr(12'h11c, be(`ACT_OPEN, `M_NONE, 8'hf2, 8'h03, 8'h00));
    wr(12'h120, be(`ACT_SET, `M_ALT, `K_D9, 8'h21, 8'h02));
    wr(12'h1c4, be(`ACT_SET, `M_ALT, `K_F12, 8'h09, 8'h01));
    rd(12'h104, be(`ACT_SET, `M_SHIFT, `K_F1, 8'h34, 8'h56), 2'b00);
    hit(`K_F1, `M_SHIFT, 1, {`ACT_CYCLE, 8'h12});
    hit(`K_LA, `M_CTRL, 1, {`ACT_JAM, 8'h07});
    hit(8'h42, `M_NONE, 0, 12'h0);
    hit(8'h92, `M_NONE, 0, 12'h0);
    hit(`K_D9, `M_ALT, 1, {`ACT_SET, 8'h21});
    chk(act_value, 8'h02);
    chk(act_store, 1'b1);
    hit(`K_F12, `M_ALT, 1, {`ACT_SET, 8'h09});
    hit(`K_F12, `M_NONE, 0, 12'h0);
    wr(`A_OUTSET, 32'h818);
    rd(`A_OUTSET, 32'h818, 2'b00);
    for (int t = 0; t < 5; t++) begin
      ts <= t[2:0];
      idle(3);
      chk({c_oe, c_out}, {6'h0a, 6'h3f ^ {2'b00, t == 3, 1'b0, t == 2, 1'b0}});
    end
    ts <= 3'h0;
    pin(3, 20, 1, {`ACT_TOGGLE, 8'h00});
    chk(tog, 2'b01);
    pin(3, 20, 1, {`ACT_TOGGLE, 8'h00});
    chk(tog, 2'b00);
    pin(1, 20, 1, {`ACT_MOMENT, 8'h05});
    pin(1, 3, 0, 12'h0);
    pin(2, 20, 0, 12'h0);
    wr(`A_OUTSET, 32'h800);
    pin(2, 20, 1, {`ACT_OPEN, 8'h03});
    chk(act_open, 1'b1);
    wr(`A_CTRL, 32'h5);
    key(8'h48, `M_NONE);
    key(8'h4a, `M_NONE);
    key(`K_BKSP, `M_NONE);
    key(8'h4b, `M_NONE);
    key(`K_UP, `M_NONE);
    key(`K_UP, `M_NONE);
    key(`K_DOWN, `M_NONE);
    key(`K_ENTER, `M_NONE);
    chk(n_done, 1);
    rd(`A_STR0, 32'h48, 2'b00);
    rd(12'h204, 32'h4b, 2'b00);
    rd(12'h208, 32'h01, 2'b00);
    wr(`A_CTRL, 32'h5);
    key(8'h5a, `M_NONE);
    key(`K_ESC, `M_NONE);
    rd(`A_STR0, 32'h48, 2'b00);
    chk(n_done, 1);
    wr(`A_CTRL, 32'h7);
    key(8'h51, `M_NONE);
    key(`K_ENTER, `M_NONE);
    key(`K_ENTER, `M_CTRL);
    chk(n_done, 2);
    rd(`A_STR0, 32'h51, 2'b00);
    rd(12'h204, 32'h0a, 2'b00);
    wr(`A_CTRL, 32'h8);
    key(`K_D0, `M_NONE);
    key(`K_D0, `M_NONE);
    chk(n_jump, 0);
    key(8'h34, `M_NONE);
    key(8'h32, `M_NONE);
    chk({n_jump[7:0], l_jump}, {8'h01, 7'h2a});
    key(`K_D9, `M_NONE);
    key(`K_D9, `M_NONE);
    chk({n_jump[7:0], l_jump}, {8'h02, 7'h63});
    conclude;
  end

  // Whole sequence needs well under 20000 cycles
  initial begin
    #(25 * 40000);
    failures++;
    conclude;
  end
endmodule // test_keyboard_shortcut_dispatcher

// ### logic/kbd_dispatch_regs.vh
`ifndef KBD_DISPATCH_REGS_VH
`define KBD_DISPATCH_REGS_VH
// Register byte offsets
`define A_CTRL        12'h000
`define A_STATUS      12'h004
`define A_OUTSET      12'h008
`define A_TOGGLE      12'h00c
`define A_BIND0       12'h100
`define A_STR0        12'h200
// Control fields
`define CTRL_EDIT_GO  0
`define CTRL_LB_OK    1
`define CTRL_SCENE    2
`define CTRL_MENU     3
`define CTRL_RST      4'h0
// Binding entry fields
`define BE_VALID      31
`define BE_ACT_HI     30
`define BE_ACT_LO     27
`define BE_MOD_HI     26
`define BE_MOD_LO     24
`define BE_KEY_HI     23
`define BE_KEY_LO     16
`define BE_TGT_HI     15
`define BE_TGT_LO     8
`define BE_VAL_HI     7
`define BE_VAL_LO     0
// Key codes
`define K_LF          8'h0a
`define K_BKSP        8'h08
`define K_ENTER       8'h0d
`define K_ESC         8'h1b
`define K_SPACE       8'h20
`define K_TILDE       8'h7e
`define K_UP          8'h80
`define K_DOWN        8'h81
`define K_F1          8'h91
`define K_F12         8'h9c
`define K_C1          8'hf1
`define K_C6          8'hf6
`define K_D0          8'h30
`define K_D9          8'h39
`define K_LA          8'h41
`define K_LZ          8'h5a
// Modifier encodings
`define M_NONE        3'h0
`define M_SHIFT       3'h1
`define M_CTRL        3'h2
`define M_ALT         3'h4
// Actions
`define ACT_MOMENT    4'h1
`define ACT_TOGGLE    4'h2
`define ACT_OPEN      4'h3
`define ACT_CYCLE     4'h4
`define ACT_SET       4'h5
`define ACT_OPEN_TC   4'h6
`define ACT_JAM       4'h7
`define ACT_EDIT_TC   4'h8
`define ACT_BTN_SC    4'h9
// Contact output conditions
`define OC_NONE       3'h0
`define OC_BITS       3
`define OUTSET_RST    18'h00000
// Debounce time
`define DB_TIME_US    5000
`define CLK_MHZ       40
`define DB_CYCLES     (`DB_TIME_US * `CLK_MHZ)
`endif

// ### logic/keyboard_shortcut_dispatcher.v
// Overview of operation
// - Table of up to 50 numbered bindings, each key or contact to one action.
// - Duplicate key sequence: only the lowest-numbered binding acts.
// - F-keys alone or with one modifier; digits, letters only Ctrl/Alt.
// - Each of six contact pins configurable as input or output.
// - Contact input asserted only while grounded; asserting triggers its binding.
// - Contact output drives low when its condition is active, high otherwise.
// - Contact input behaves as one more keyboard key.
// - Contact selection number N refers to physical pin N.
// - Output follows one condition: undefined, stopped, playing, recording, paused.
// - Pin set as both input and output works only as output.
// - Momentary button action only from contacts; emulates the button anywhere.
// - Toggle action only from contacts; flips play or record only.
// - Cycle action advances target parameter and stores it.
// - Set action loads the binding value into the target and stores it.
// - Jam action applies a time code jam with no edit screen.
// - One binding gives one action; no macros.
// - Backspace removes character before cursor and moves cursor left.
// - Up and down arrows step the character code up or down.
// - Enter breaks line where allowed, else commits; Ctrl+Enter commits.
// - Scene editing: printable key writes at cursor then advances.
// - Two typed digits in the setup menu jump to that entry.
// - Escape leaves the editor and discards all changes.
`timescale 1ns/10ps
`include "kbd_dispatch_regs.vh"
module keyboard_shortcut_dispatcher #(
  parameter NBIND     = 50,
  parameter STRLEN    = 16,
  parameter DB_CYCLES = `DB_CYCLES,
  parameter DBW       = 18
) (
  input  wire        SYS_CLK,
  input  wire        RESET_N,
  input  wire [11:0] S_AXI_AWADDR,
  input  wire        S_AXI_AWVALID,
  output reg         S_AXI_AWREADY,
  input  wire [31:0] S_AXI_WDATA,
  input  wire [3:0]  S_AXI_WSTRB,
  input  wire        S_AXI_WVALID,
  output reg         S_AXI_WREADY,
  output reg  [1:0]  S_AXI_BRESP,
  output reg         S_AXI_BVALID,
  input  wire        S_AXI_BREADY,
  input  wire [11:0] S_AXI_ARADDR,
  input  wire        S_AXI_ARVALID,
  output reg         S_AXI_ARREADY,
  output reg  [31:0] S_AXI_RDATA,
  output reg  [1:0]  S_AXI_RRESP,
  output reg         S_AXI_RVALID,
  input  wire        S_AXI_RREADY,
  input  wire        KEY_VALID,
  input  wire [7:0]  KEY_CODE,
  input  wire [2:0]  KEY_MOD,
  output reg         KEY_READY,
  input  wire [5:0]  CONTACT_IN,
  output reg  [5:0]  CONTACT_OUT,
  output reg  [5:0]  CONTACT_OE,
  input  wire [2:0]  TRANSPORT_STATE,
  output reg         ACT_VALID,
  output reg  [3:0]  ACT_TYPE,
  output reg  [7:0]  ACT_TARGET,
  output reg  [7:0]  ACT_VALUE,
  output reg         ACT_STORE,
  output reg         ACT_OPEN_UI,
  output reg  [1:0]  TOGGLE_STATE,
  output reg         JUMP_VALID,
  output reg  [6:0]  JUMP_NUM,
  output reg         EDIT_DONE
);

  localparam ST_IDLE = 3'b001;
  localparam ST_SCAN = 3'b010;
  localparam ST_EMIT = 3'b100;

  function legal_key;
    input [7:0] k;
    input [2:0] m;
    reg         one;
    begin
      one = (m == `M_SHIFT) || (m == `M_CTRL) || (m == `M_ALT);
      legal_key =
        ((k >= `K_F1) && (k <= `K_F12) && ((m == `M_NONE) || one)) ||
        ((((k >= `K_D0) && (k <= `K_D9)) || ((k >= `K_LA) && (k <= `K_LZ)))
          && ((m == `M_CTRL) || (m == `M_ALT))) ||
        ((k >= `K_C1) && (k <= `K_C6) && (m == `M_NONE));
    end
  endfunction

  reg [31:0] bind_mem [0:NBIND-1];
  reg [7:0]  str_w [0:STRLEN-1];
  reg [7:0]  str_c [0:STRLEN-1];
  reg [3:0]  ctrl_r;
  reg [17:0] outset_r;
  reg [11:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0]  wstrb_r;
  reg [11:0] araddr_r;
  reg        rd_pend_r;
  reg [2:0]  state_r;
  reg [5:0]  idx_r;
  reg [7:0]  cur_key_r;
  reg [2:0]  cur_mod_r;
  reg [31:0] hit_r;
  reg [5:0]  pend_r;
  reg        editing_r;
  reg [4:0]  cursor_r;
  reg        digit_have_r;
  reg [3:0]  digit_hi_r;
  reg        edit_go_r;
  wire [5:0] fall;
  integer    i;
  integer    ip;
  integer    ie;

  // Register bus decode
  wire        wr_exec = ~S_AXI_AWREADY & ~S_AXI_WREADY & ~S_AXI_BVALID;
  wire [11:0] wb_off  = awaddr_r - `A_BIND0;
  wire [11:0] ws_off  = awaddr_r - `A_STR0;
  wire [11:0] rb_off  = araddr_r - `A_BIND0;
  wire [11:0] rs_off  = araddr_r - `A_STR0;
  wire        wr_bind = (awaddr_r >= `A_BIND0) && (wb_off[11:2] < NBIND);
  wire        wr_str  = (awaddr_r >= `A_STR0) && (ws_off[11:2] < STRLEN);
  wire        rd_bind = (araddr_r >= `A_BIND0) && (rb_off[11:2] < NBIND);
  wire        rd_str  = (araddr_r >= `A_STR0) && (rs_off[11:2] < STRLEN);
  wire [31:0] wmask   = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}},
                         {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  wire [31:0] bind_old = bind_mem[wb_off[7:2]];
  wire        wr_ok   = wr_bind || wr_str || (awaddr_r == `A_CTRL) ||
                        (awaddr_r == `A_STATUS) || (awaddr_r == `A_OUTSET) ||
                        (awaddr_r == `A_TOGGLE);

  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_AWREADY <= 1'b1;
      S_AXI_WREADY  <= 1'b1;
      S_AXI_BVALID  <= 1'b0;
      S_AXI_BRESP   <= 2'b00;
      awaddr_r      <= 12'h000;
      wdata_r       <= 32'h00000000;
      wstrb_r       <= 4'h0;
      ctrl_r        <= `CTRL_RST;
      edit_go_r     <= 1'b0;
      outset_r      <= `OUTSET_RST;
      for (i = 0; i < NBIND; i = i + 1)
        bind_mem[i] <= 32'h00000000;
    end else begin
      edit_go_r <= 1'b0;
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        awaddr_r      <= {S_AXI_AWADDR[11:2], 2'b00};
        S_AXI_AWREADY <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        wdata_r      <= S_AXI_WDATA;
        wstrb_r      <= S_AXI_WSTRB;
        S_AXI_WREADY <= 1'b0;
      end
      if (wr_exec) begin
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP  <= wr_ok ? 2'b00 : 2'b10;
        if (wr_bind)
          bind_mem[wb_off[7:2]] <= (bind_old & ~wmask) | (wdata_r & wmask);
        if (awaddr_r == `A_CTRL && wstrb_r[0]) begin
          ctrl_r    <= wdata_r[`CTRL_MENU:`CTRL_EDIT_GO];
          edit_go_r <= wdata_r[`CTRL_EDIT_GO];
        end
        if (awaddr_r == `A_OUTSET)
          outset_r <= (outset_r & ~wmask[17:0]) | (wdata_r[17:0] & wmask[17:0]);
      end
      if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID  <= 1'b0;
        S_AXI_AWREADY <= 1'b1;
        S_AXI_WREADY  <= 1'b1;
      end
    end
  end

  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      S_AXI_ARREADY <= 1'b1;
      S_AXI_RVALID  <= 1'b0;
      S_AXI_RDATA   <= 32'h00000000;
      S_AXI_RRESP   <= 2'b00;
      araddr_r      <= 12'h000;
      rd_pend_r     <= 1'b0;
    end else begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        araddr_r      <= {S_AXI_ARADDR[11:2], 2'b00};
        S_AXI_ARREADY <= 1'b0;
        rd_pend_r     <= 1'b1;
      end
      if (rd_pend_r) begin
        rd_pend_r    <= 1'b0;
        S_AXI_RVALID <= 1'b1;
        S_AXI_RRESP  <= 2'b00;
        S_AXI_RDATA  <= 32'h00000000;
        if (rd_bind)
          S_AXI_RDATA <= bind_mem[rb_off[7:2]];
        else if (rd_str)
          S_AXI_RDATA <= {24'h000000, str_c[rs_off[5:2]]};
        else if (araddr_r == `A_CTRL)
          S_AXI_RDATA <= {28'h0000000, ctrl_r[3:1], 1'b0};
        else if (araddr_r == `A_STATUS)
          S_AXI_RDATA <= {19'h00000, cursor_r, pend_r,
                          state_r[0], editing_r};
        else if (araddr_r == `A_OUTSET)
          S_AXI_RDATA <= {14'h0000, outset_r};
        else if (araddr_r == `A_TOGGLE)
          S_AXI_RDATA <= {30'h00000000, TOGGLE_STATE};
        else
          S_AXI_RRESP <= 2'b10;
      end
      if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID  <= 1'b0;
        S_AXI_ARREADY <= 1'b1;
      end
    end
  end

  // Contact pins: sync, debounce, output drive
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : pin
      reg           s1_r;
      reg           s2_r;
      reg           lvl_r;
      reg [DBW-1:0] cnt_r;
      wire [2:0]    cond = outset_r[g*`OC_BITS +: `OC_BITS];
      // Long settle time rides out mechanical bounce
      always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          s1_r  <= 1'b1;
          s2_r  <= 1'b1;
          lvl_r <= 1'b1;
          cnt_r <= {DBW{1'b0}};
        end else begin
          s1_r <= CONTACT_IN[g];
          s2_r <= s1_r;
          if (s2_r == lvl_r)
            cnt_r <= {DBW{1'b0}};
          else if (cnt_r == DB_CYCLES[DBW-1:0] - 1'b1) begin
            lvl_r <= s2_r;
            cnt_r <= {DBW{1'b0}};
          end else
            cnt_r <= cnt_r + 1'b1;
        end
      end
      assign fall[g] = (s2_r != lvl_r) & ~s2_r & (cond == `OC_NONE) &
                       (cnt_r == DB_CYCLES[DBW-1:0] - 1'b1);
      always @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
          CONTACT_OE[g]  <= 1'b0;
          CONTACT_OUT[g] <= 1'b1;
        end else begin
          CONTACT_OE[g]  <= (cond != `OC_NONE);
          CONTACT_OUT[g] <= ~((cond != `OC_NONE) &&
                              (cond == TRANSPORT_STATE + 3'h1));
        end
      end
    end
  endgenerate

  // Lookup and dispatch
  wire        key_take = KEY_VALID & KEY_READY;
  wire        is_digit = (KEY_CODE >= `K_D0) && (KEY_CODE <= `K_D9);
  wire        to_edit  = editing_r;
  wire        to_jump  = ~editing_r & ctrl_r[`CTRL_MENU] & is_digit &
                         (KEY_MOD == `M_NONE);
  wire [31:0] ent      = bind_mem[idx_r];
  wire        match    = ent[`BE_VALID] &&
                         (ent[`BE_KEY_HI:`BE_KEY_LO] == cur_key_r) &&
                         (ent[`BE_MOD_HI:`BE_MOD_LO] == cur_mod_r) &&
                         legal_key(cur_key_r, cur_mod_r);
  wire        from_pin = (cur_key_r >= `K_C1) && (cur_key_r <= `K_C6);
  wire [3:0]  hit_act  = hit_r[`BE_ACT_HI:`BE_ACT_LO];
  reg  [2:0]  pick;
  reg  [5:0]  pend_clr;
  always @* begin
    pick     = 3'd0;
    pend_clr = 6'h00;
    for (ip = 5; ip >= 0; ip = ip - 1)
      if (pend_r[ip])
        pick = ip[2:0];
    if (state_r == ST_IDLE && !key_take && pend_r != 6'h00)
      pend_clr[pick] = 1'b1;
  end

  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      state_r      <= ST_IDLE;
      KEY_READY    <= 1'b1;
      idx_r        <= 6'd0;
      cur_key_r    <= 8'h00;
      cur_mod_r    <= `M_NONE;
      hit_r        <= 32'h00000000;
      pend_r       <= 6'h00;
      ACT_VALID    <= 1'b0;
      ACT_TYPE     <= 4'h0;
      ACT_TARGET   <= 8'h00;
      ACT_VALUE    <= 8'h00;
      ACT_STORE    <= 1'b0;
      ACT_OPEN_UI  <= 1'b0;
      TOGGLE_STATE <= 2'b00;
      JUMP_VALID   <= 1'b0;
      JUMP_NUM     <= 7'd0;
      digit_have_r <= 1'b0;
      digit_hi_r   <= 4'h0;
    end else begin
      ACT_VALID  <= 1'b0;
      JUMP_VALID <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (key_take && to_jump) begin
            digit_have_r <= ~digit_have_r;
            digit_hi_r   <= KEY_CODE[3:0];
            if (digit_have_r && (digit_hi_r != 4'h0 || KEY_CODE[3:0] != 4'h0)) begin
              JUMP_VALID <= 1'b1;
              JUMP_NUM   <= digit_hi_r * 7'd10 + {3'b000, KEY_CODE[3:0]};
            end
          end else if (key_take && !to_edit) begin
            digit_have_r <= 1'b0;
            cur_key_r    <= KEY_CODE;
            cur_mod_r    <= KEY_MOD;
            idx_r        <= 6'd0;
            state_r      <= ST_SCAN;
            KEY_READY    <= 1'b0;
          end else if (!key_take && pend_r != 6'h00) begin
            cur_key_r <= `K_C1 + {5'b00000, pick};
            cur_mod_r <= `M_NONE;
            idx_r     <= 6'd0;
            state_r   <= ST_SCAN;
            KEY_READY <= 1'b0;
          end
        end
        ST_SCAN: begin
          // First hit in ascending order ends the scan
          if (match) begin
            hit_r   <= ent;
            state_r <= ST_EMIT;
          end else if (idx_r == NBIND - 1) begin
            state_r   <= ST_IDLE;
            KEY_READY <= 1'b1;
          end else
            idx_r <= idx_r + 6'd1;
        end
        ST_EMIT: begin
          state_r   <= ST_IDLE;
          KEY_READY <= 1'b1;
          if ((hit_act != `ACT_MOMENT && hit_act != `ACT_TOGGLE) ||
              from_pin) begin
            ACT_VALID   <= 1'b1;
            ACT_TYPE    <= hit_act;
            ACT_TARGET  <= hit_r[`BE_TGT_HI:`BE_TGT_LO];
            ACT_VALUE   <= hit_r[`BE_VAL_HI:`BE_VAL_LO];
            ACT_STORE   <= (hit_act == `ACT_CYCLE) ||
                           (hit_act == `ACT_SET);
            ACT_OPEN_UI <= (hit_act == `ACT_OPEN) ||
                           (hit_act == `ACT_OPEN_TC) ||
                           (hit_act == `ACT_EDIT_TC);
          end
          if (hit_act == `ACT_TOGGLE && from_pin &&
              hit_r[`BE_TGT_HI:`BE_TGT_LO] < 8'd2)
            TOGGLE_STATE[hit_r[`BE_TGT_LO]] <=
              ~TOGGLE_STATE[hit_r[`BE_TGT_LO]];
        end
        default: begin
          state_r   <= ST_IDLE;
          KEY_READY <= 1'b1;
        end
      endcase
      pend_r <= (pend_r & ~pend_clr) | fall;
    end
  end

  // String editor
  wire [7:0] at_cur = str_w[cursor_r[3:0]];
  wire       commit = key_take && to_edit && (KEY_CODE == `K_ENTER) &&
                      (!ctrl_r[`CTRL_LB_OK] || KEY_MOD == `M_CTRL);
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      editing_r <= 1'b0;
      cursor_r  <= 5'd0;
      EDIT_DONE <= 1'b0;
      for (ie = 0; ie < STRLEN; ie = ie + 1) begin
        str_w[ie] <= 8'h00;
        str_c[ie] <= 8'h00;
      end
    end else begin
      EDIT_DONE <= 1'b0;
      if (wr_exec && wr_str && wstrb_r[0])
        str_c[ws_off[5:2]] <= wdata_r[7:0];
      if (edit_go_r) begin
        editing_r <= 1'b1;
        cursor_r  <= 5'd0;
        for (ie = 0; ie < STRLEN; ie = ie + 1)
          str_w[ie] <= str_c[ie];
      end else if (commit) begin
        editing_r <= 1'b0;
        EDIT_DONE <= 1'b1;
        for (ie = 0; ie < STRLEN; ie = ie + 1)
          str_c[ie] <= str_w[ie];
      end else if (key_take && to_edit) begin
        if (KEY_CODE == `K_ESC)
          editing_r <= 1'b0;
        else if (KEY_CODE == `K_BKSP && cursor_r != 5'd0) begin
          for (ie = 0; ie < STRLEN - 1; ie = ie + 1)
            if (ie >= cursor_r - 1)
              str_w[ie] <= str_w[ie+1];
          str_w[STRLEN-1] <= 8'h00;
          cursor_r <= cursor_r - 5'd1;
        end else if (KEY_CODE == `K_UP)
          str_w[cursor_r[3:0]] <= at_cur + 8'h01;
        else if (KEY_CODE == `K_DOWN)
          str_w[cursor_r[3:0]] <= at_cur - 8'h01;
        else if (KEY_CODE == `K_ENTER) begin
          // Line break shifts the tail right; last character falls off
          for (ie = 1; ie < STRLEN; ie = ie + 1)
            if (ie > cursor_r)
              str_w[ie] <= str_w[ie-1];
          str_w[cursor_r[3:0]] <= `K_LF;
          if (cursor_r < STRLEN - 1)
            cursor_r <= cursor_r + 5'd1;
        end else if (ctrl_r[`CTRL_SCENE] && KEY_MOD == `M_NONE &&
                     KEY_CODE >= `K_SPACE && KEY_CODE <= `K_TILDE) begin
          str_w[cursor_r[3:0]] <= KEY_CODE;
          if (cursor_r < STRLEN - 1)
            cursor_r <= cursor_r + 5'd1;
        end
      end
    end
  end

endmodule // keyboard_shortcut_dispatcher
